// *** core/rmc_top.sv ***
`timescale 1ns/1ps
`include "rmc_cfg.svh"

module rmc_top
    import rmc_pkg::*;
#(
    parameter int ECO_DELAY_CYC   = `RMC_CYC_ECO,
    parameter int SUPER_DELAY_CYC = `RMC_CYC_SUPER
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        internal_fast_osc_run,
    input  wire logic        external_fast_osc_run,
    input  wire logic        external_clock_input_run,
    input  wire logic        cpu_sleep,
    input  wire logic        crystal_sleep_stop_ctl,
    output logic             regulator_economy,
    output logic             charge_pump_en,
    output logic      [1:0]  charge_pump_clk_div,
    output logic             irq
);
    import rmc_pkg::*;

    localparam int TW = 18;

    initial
    begin
        if (ECO_DELAY_CYC < 2 || ECO_DELAY_CYC >= (1 << TW))
            $error("rmc_top: ECO_DELAY_CYC out of range");
        if (SUPER_DELAY_CYC < 2 || SUPER_DELAY_CYC >= (1 << TW))
            $error("rmc_top: SUPER_DELAY_CYC out of range");
    end

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] pins_s;
    logic       fast_run;
    logic       sleep_s;
    logic       xtal_stop_s;
    logic       sleep_d_r;
    logic       sleep_entry;
    logic       sleep_exit;

    rmc_sync2 #(
        .W (5)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({crystal_sleep_stop_ctl, cpu_sleep,
                   external_clock_input_run, external_fast_osc_run,
                   internal_fast_osc_run}),
        .q       (pins_s)
    );

    assign fast_run    = |pins_s[2:0];
    assign sleep_s     = pins_s[3];
    assign xtal_stop_s = pins_s[4];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sleep_d_r <= 1'b0;
        else
            sleep_d_r <= sleep_s;
    end

    assign sleep_entry = sleep_s & ~sleep_d_r;
    assign sleep_exit  = ~sleep_s & sleep_d_r;

    // ****************************************
    // apb access decode
    // ****************************************
    logic setup_ph;
    logic acc_wr;
    logic acc_rd;
    logic hit_protect;
    logic hit_mode;
    logic hit_timing;
    logic hit_status;
    logic hit_istat;
    logic hit_imask;
    logic hit_any;

    assign setup_ph = psel & ~penable;
    assign acc_wr   = psel & penable & pready & pwrite;
    assign acc_rd   = psel & penable & pready & ~pwrite;

    always_comb
    begin
        hit_protect = 1'b0;
        hit_mode    = 1'b0;
        hit_timing  = 1'b0;
        hit_status  = 1'b0;
        hit_istat   = 1'b0;
        hit_imask   = 1'b0;
        if (paddr == `RMC_OFS_PROTECT)
            hit_protect = 1'b1;
        else if (paddr == `RMC_OFS_MODE_CTL)
            hit_mode = 1'b1;
        else if (paddr == `RMC_OFS_TIMING)
            hit_timing = 1'b1;
        else if (paddr == `RMC_OFS_STATUS)
            hit_status = 1'b1;
        else if (paddr == `RMC_OFS_INT_STAT)
            hit_istat = 1'b1;
        else if (paddr == `RMC_OFS_INT_MASK)
            hit_imask = 1'b1;
    end

    assign hit_any = hit_protect | hit_mode | hit_timing | hit_status
                   | hit_istat | hit_imask;

    // ****************************************
    // protection and configuration
    // ****************************************
    logic      unlocked_r;
    rmc_mode_t mode_sel_r;
    logic      mode_legal;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unlocked_r <= 1'b0;
        else if (acc_wr && hit_protect)
            unlocked_r <= (pwdata[15:0] == `RMC_PROTECT_KEY);
    end

    assign mode_legal = (pwdata[2:0] == `RMC_MODE_AUTO)
                      | (pwdata[2:0] == `RMC_MODE_NORMAL)
                      | (pwdata[2:0] == `RMC_MODE_ECONOMY)
                      | (pwdata[2:0] == `RMC_MODE_SUPER);

    // reserved codes are dropped rather than guessed at
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            mode_sel_r <= `RMC_MODE_RST;
        else if (acc_wr && hit_mode && unlocked_r && mode_legal)
            mode_sel_r <= pwdata[2:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            charge_pump_clk_div <= `RMC_CPDIV_RST;
        else if (acc_wr && hit_timing && unlocked_r)
            charge_pump_clk_div <= pwdata[1:0];
    end

    // ****************************************
    // regulation state machine
    // ****************************************
    rmc_state_t  state_r;
    rmc_state_t  state_nxt;
    logic        tmr_load;
    logic [TW-1:0] tmr_val;
    logic        tmr_abort;
    logic        tmr_busy;
    logic        tmr_done;
    logic        done_evt;

    rmc_delay_timer #(
        .W (TW)
    ) u_tmr (
        .pclk     (pclk),
        .presetn  (presetn),
        .load     (tmr_load),
        .load_val (tmr_val),
        .abort    (tmr_abort),
        .busy     (tmr_busy),
        .done     (tmr_done)
    );

    always_comb
    begin
        state_nxt = state_r;
        tmr_load  = 1'b0;
        tmr_val   = TW'(ECO_DELAY_CYC);
        tmr_abort = 1'b0;
        done_evt  = 1'b0;
        if (mode_sel_r == `RMC_MODE_SUPER)
        begin
            state_nxt = RMC_ST_SUPER;
            tmr_abort = 1'b1;
        end
        else if (state_r == RMC_ST_SUPER)
        begin
            // recover always follows super, whatever mode other than super is selected
            state_nxt = RMC_ST_RECOVER;
            tmr_load  = 1'b1;
            tmr_val   = TW'(SUPER_DELAY_CYC);
        end
        else if (state_r == RMC_ST_RECOVER)
        begin
            // pump hand-over runs its full time in any mode but super
            if (tmr_done)
            begin
                done_evt  = 1'b1;
                state_nxt = RMC_ST_ECONOMY;
            end
        end
        else if (mode_sel_r == `RMC_MODE_NORMAL)
        begin
            state_nxt = RMC_ST_NORMAL;
            tmr_abort = 1'b1;
        end
        else if (mode_sel_r == `RMC_MODE_ECONOMY)
        begin
            state_nxt = RMC_ST_ECONOMY;
            tmr_abort = 1'b1;
        end
        else
        begin
            case (state_r)
                RMC_ST_NORMAL:
                begin
                    if (sleep_entry && xtal_stop_s)
                        state_nxt = RMC_ST_ECONOMY;
                    else if (sleep_entry || (!fast_run && !sleep_s))
                    begin
                        state_nxt = RMC_ST_WAIT;
                        tmr_load  = 1'b1;
                    end
                end
                RMC_ST_WAIT:
                begin
                    if (sleep_exit)
                    begin
                        state_nxt = fast_run ? RMC_ST_NORMAL
                                             : RMC_ST_ECONOMY;
                        tmr_abort = 1'b1;
                    end
                    else if (fast_run && !sleep_s)
                    begin
                        state_nxt = RMC_ST_NORMAL;
                        tmr_abort = 1'b1;
                    end
                    else if (tmr_done)
                    begin
                        state_nxt = RMC_ST_ECONOMY;
                        done_evt  = 1'b1;
                    end
                end
                RMC_ST_ECONOMY:
                begin
                    if (sleep_exit)
                        state_nxt = fast_run ? RMC_ST_NORMAL
                                             : RMC_ST_ECONOMY;
                    else if (fast_run)
                        state_nxt = RMC_ST_NORMAL;
                end
                default:
                    state_nxt = RMC_ST_NORMAL;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= RMC_ST_NORMAL;
        else
            state_r <= state_nxt;
    end

    // outputs change on the same edge as the state, straight from flops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            regulator_economy <= 1'b0;
            charge_pump_en    <= 1'b0;
        end
        else
        begin
            regulator_economy <= (state_nxt == RMC_ST_ECONOMY)
                               | (state_nxt == RMC_ST_RECOVER);
            charge_pump_en    <= (state_nxt == RMC_ST_SUPER);
        end
    end

    // ****************************************
    // completion flag and interrupts
    // ****************************************
    logic                 done_flag_r;
    logic [`RMC_INT_W-1:0] int_stat_r;
    logic [`RMC_INT_W-1:0] int_mask_r;
    logic [`RMC_INT_W-1:0] int_set;
    logic                 reg_change;

    assign reg_change = (state_nxt != state_r);
    assign int_set    = {reg_change, done_evt};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_flag_r <= 1'b0;
        else if (done_evt)
            done_flag_r <= 1'b1;
        else if (acc_wr && hit_status && pwdata[0])
            done_flag_r <= 1'b0;
    end

    // read clears only what it reported; data was latched at setup,
    // so an event landing between setup and access is kept
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_stat_r <= '0;
        else if (acc_rd && hit_istat)
            int_stat_r <= (int_stat_r & ~prdata[`RMC_INT_W-1:0]) | int_set;
        else
            int_stat_r <= int_stat_r | int_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            int_mask_r <= '0;
        else if (acc_wr && hit_imask)
            int_mask_r <= pwdata[`RMC_INT_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(int_stat_r & int_mask_r);
    end

    // ****************************************
    // apb answer: no wait states, data from flops
    // ****************************************
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (hit_protect)
            rd_mux = {31'h0000_0000, unlocked_r};
        else if (hit_mode)
            rd_mux = {29'h0000_0000, mode_sel_r};
        else if (hit_timing)
            rd_mux = {30'h0000_0000, charge_pump_clk_div};
        else if (hit_status)
            rd_mux = {24'h00_0000, 1'b0, done_flag_r, tmr_busy, state_r};
        else if (hit_istat)
            rd_mux = {30'h0000_0000, int_stat_r};
        else if (hit_imask)
            rd_mux = {30'h0000_0000, int_mask_r};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
        else
        begin
            pready  <= setup_ph;
            pslverr <= setup_ph & ~hit_any;
            prdata  <= setup_ph ? rd_mux : 32'h0000_0000;
        end
    end

endmodule

// *** core/rmc_cfg.svh ***
`ifndef RMC_CFG_SVH
`define RMC_CFG_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define RMC_OFS_PROTECT   12'h000
`define RMC_OFS_MODE_CTL  12'h004
`define RMC_OFS_TIMING    12'h008
`define RMC_OFS_STATUS    12'h00c
`define RMC_OFS_INT_STAT  12'h010
`define RMC_OFS_INT_MASK  12'h014

// ****************************************
// field layout and values
// ****************************************
`define RMC_PROTECT_KEY   16'h0096
`define RMC_MODE_AUTO     3'h0
`define RMC_MODE_NORMAL   3'h2
`define RMC_MODE_ECONOMY  3'h3
`define RMC_MODE_SUPER    3'h5
`define RMC_MODE_RST      3'h0
`define RMC_CPDIV_RST     2'h0
`define RMC_INT_DONE_BIT  0
`define RMC_INT_REG_BIT   1
`define RMC_INT_W         2

// ****************************************
// timing
// ****************************************
`define RMC_CLK_MHZ       20
`define RMC_T_ECO_US      1000
`define RMC_T_SUPER_US    10000
`define RMC_CYC_ECO       (`RMC_T_ECO_US * `RMC_CLK_MHZ)
`define RMC_CYC_SUPER     (`RMC_T_SUPER_US * `RMC_CLK_MHZ)

`endif

// *** core/rmc_pkg.sv ***
package rmc_pkg;

    typedef enum logic [4:0] {
        RMC_ST_NORMAL  = 5'h01,
        RMC_ST_WAIT    = 5'h02,
        RMC_ST_ECONOMY = 5'h04,
        RMC_ST_SUPER   = 5'h08,
        RMC_ST_RECOVER = 5'h10
    } rmc_state_t;

    typedef logic [2:0] rmc_mode_t;

endpackage

// *** core/rmc_sync2.sv ***
`timescale 1ns/1ps

module rmc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_r <= '0;
            q      <= '0;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

// *** core/rmc_delay_timer.sv ***
`timescale 1ns/1ps

module rmc_delay_timer #(
    parameter int W = 18
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         abort,
    output logic              busy,
    output logic              done
);
    logic [W-1:0] cnt_r;

    initial
    begin
        if (W < 2 || W > 31)
            $error("rmc_delay_timer: width out of range");
    end

    // load wins over abort so a fresh start is never lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_r <= '0;
            busy  <= 1'b0;
            done  <= 1'b0;
        end
        else if (load)
        begin
            cnt_r <= load_val - W'(1);
            busy  <= 1'b1;
            done  <= 1'b0;
        end
        else if (abort)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else if (busy)
        begin
            done <= (cnt_r == W'(1));
            busy <= (cnt_r != W'(1));
            cnt_r <= cnt_r - W'(1);
        end
        else
            done <= 1'b0;
    end
endmodule

// *** verification/rmc_top_chk.sv ***
`timescale 1ns/1ps
`include "rmc_cfg.svh"

module rmc_top_chk #(
    parameter int ECO_DELAY_CYC   = `RMC_CYC_ECO,
    parameter int SUPER_DELAY_CYC = `RMC_CYC_SUPER
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        internal_fast_osc_run,
    input wire logic        external_fast_osc_run,
    input wire logic        external_clock_input_run,
    input wire logic        cpu_sleep,
    input wire logic        crystal_sleep_stop_ctl,
    input wire logic        regulator_economy,
    input wire logic        charge_pump_en,
    input wire logic [1:0]  charge_pump_clk_div,
    input wire logic        irq
);
    // ******
    // completed writes, as the slave sees them
    // ******
    logic wr_acc;
    logic wr_mode;
    logic wr_super;
    logic wr_tim;

    assign wr_acc   = psel && penable && pready && pwrite;
    assign wr_mode  = wr_acc && paddr == `RMC_OFS_MODE_CTL;
    assign wr_super = wr_mode && pwdata[2:0] == `RMC_MODE_SUPER;
    assign wr_tim   = wr_acc && paddr == `RMC_OFS_TIMING;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_setup; psel && !penable |=> pready; endproperty
    a_setup: assert property (p_setup) else $error("no ready");
    property p_once; pready |=> !pready; endproperty
    a_once: assert property (p_once) else $error("ready held");
    property p_idle; !pready |-> prdata == 32'h0 && !pslverr; endproperty
    a_idle: assert property (p_idle) else $error("idle bus");
    // pump enable moves only after a completed mode write
    property p_pump; $changed(charge_pump_en) |-> $past(wr_mode, 1) ||
        $past(wr_mode, 2) || $past(wr_mode, 3) || $past(wr_mode, 4);
    endproperty
    a_pump: assert property (p_pump) else $error("pump moved");
    property p_super; $rose(charge_pump_en) |-> $past(wr_super, 1) ||
        $past(wr_super, 2) || $past(wr_super, 3) || $past(wr_super, 4);
    endproperty
    a_super: assert property (p_super) else $error("pump code");
    property p_div; $changed(charge_pump_clk_div) |-> $past(wr_tim, 1) ||
        $past(wr_tim, 2) || $past(wr_tim, 3);
    endproperty
    a_div: assert property (p_div) else $error("divider moved");
    property p_fast; $rose(internal_fast_osc_run || external_fast_osc_run ||
        external_clock_input_run) && regulator_economy && !charge_pump_en
        |-> ##[1:8] !regulator_economy;
    endproperty
    a_fast: assert property (p_fast) else $error("no normal");
    property p_rec; $fell(charge_pump_en) |-> ##[0:2] regulator_economy[*8];
    endproperty
    a_rec: assert property (p_rec) else $error("no recovery");
endmodule

bind rmc_top rmc_top_chk #(
    .ECO_DELAY_CYC(ECO_DELAY_CYC), .SUPER_DELAY_CYC(SUPER_DELAY_CYC)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .internal_fast_osc_run(internal_fast_osc_run),
    .external_fast_osc_run(external_fast_osc_run),
    .external_clock_input_run(external_clock_input_run),
    .cpu_sleep(cpu_sleep), .crystal_sleep_stop_ctl(crystal_sleep_stop_ctl),
    .regulator_economy(regulator_economy), .charge_pump_en(charge_pump_en),
    .charge_pump_clk_div(charge_pump_clk_div), .irq(irq)
);

// *** verification/test_rmc_top.sv ***
`timescale 1ns/1ps
`include "rmc_cfg.svh"

module test_rmc_top;
    // ******
    // short delays keep the run small
    // ******
    localparam int          ECO = 20;
    localparam int          SUP = 50;
    localparam logic [11:0] PRT = `RMC_OFS_PROTECT;
    localparam logic [11:0] MOD = `RMC_OFS_MODE_CTL;
    localparam logic [11:0] TIM = `RMC_OFS_TIMING;
    localparam logic [11:0] STA = `RMC_OFS_STATUS;
    localparam logic [11:0] IST = `RMC_OFS_INT_STAT;
    localparam logic [11:0] IMK = `RMC_OFS_INT_MASK;
    localparam logic [31:0] KEY = {16'h0, `RMC_PROTECT_KEY};
    localparam logic [2:0]  MT [3] = '{3'h2, 3'h3, 3'h0};
    localparam logic        ME [3] = '{1'b0, 1'b1, 1'b1};

    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [2:0]  fast = 3'h1;
    logic        cpu_sleep = 1'b0;
    logic        crystal_sleep_stop_ctl = 1'b0;
    logic [31:0] prdata;
    logic        pready, pslverr, regulator_economy, charge_pump_en, irq;
    logic [1:0]  charge_pump_clk_div;
    logic [64:0] exp_q [$];
    logic [31:0] key;
    int          miscompares = 0;
    int          n_tests = 0;
    int          timer = 0;
    int          seed = 49;

    always #25 pclk = ~pclk;

    rmc_top #(.ECO_DELAY_CYC(ECO), .SUPER_DELAY_CYC(SUP)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .internal_fast_osc_run(fast[0]), .external_fast_osc_run(fast[1]),
        .external_clock_input_run(fast[2]), .cpu_sleep(cpu_sleep),
        .crystal_sleep_stop_ctl(crystal_sleep_stop_ctl),
        .regulator_economy(regulator_economy), .charge_pump_en(charge_pump_en),
        .charge_pump_clk_div(charge_pump_clk_div), .irq(irq)
    );

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp_rd(input logic [32:0] got, input logic [64:0] e);
        n_tests++;
        if ((got[31:0] & e[63:32]) !== e[31:0] || got[32] !== e[64])
        begin
            miscompares++;
            $display("Error read exp %h got %h", {e[64], e[31:0]}, got);
        end
    endtask

    task automatic cmp_pin(input string n, input logic got, input logic e);
        n_tests++;
        if (got !== e)
        begin
            miscompares++;
            $display("Error %s exp %b got %b", n, e, got);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // expected read word is queued at setup, checked by the monitor
    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] d, input logic [31:0] m,
                       input logic e);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        if (!w)
            exp_q.push_back({e, m, d & m});
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] m,
                      input logic [31:0] d);
        apb(a, 1'b0, d, m, 1'b0);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(a, 1'b1, d, 32'h0, 1'b0);
    endtask

    always @(posedge pclk)
    begin
        timer++;
        if (timer == 3000)
        begin
            miscompares++;
            final_report();
        end
        else if (psel && penable && pready === 1'b1 && !pwrite)
            cmp_rd({pslverr, prdata}, exp_q.pop_front());
    end

    // ******
    // main sequence
    // ******
    initial
    begin
        cyc(6);
        presetn <= 1'b1;
        rd(PRT, 32'h1, 32'h0);
        rd(MOD, 32'h7, 32'h0);
        rd(TIM, 32'h3, 32'h0);
        rd(IMK, 32'h3, 32'h0);
        rd(STA, 32'h1f, 32'h1);
        apb(12'h020, 1'b0, 32'h0, 32'h0, 1'b1);
        wr(MOD, 32'h3);
        wr(TIM, 32'h2);
        rd(MOD, 32'h7, 32'h0);
        rd(TIM, 32'h3, 32'h0);
        key = $random(seed) | 32'h100;
        wr(PRT, KEY);
        rd(PRT, 32'h1, 32'h1);
        wr(PRT, key);
        wr(MOD, 32'h2);
        rd(MOD, 32'h7, 32'h0);
        wr(PRT, KEY);
        wr(MOD, 32'h1);
        rd(MOD, 32'h7, 32'h0);
        fast <= 3'h0;
        for (int i = 0; i < 3; i++)
        begin
            wr(MOD, {29'h0, MT[i]});
            cyc(40);
            cmp_pin("economy", regulator_economy, ME[i]);
            rd(MOD, 32'h7, {29'h0, MT[i]});
        end
        wr(IMK, 32'h1);
        rd(IST, 32'h0, 32'h0);
        for (int i = 0; i < 3; i++)
        begin
            fast <= 3'h1 << i;
            cyc(6);
            cmp_pin("economy", regulator_economy, 1'b0);
            fast <= 3'h0;
            cyc(ECO / 2);
            cmp_pin("economy", regulator_economy, 1'b0);
            cyc(ECO);
            cmp_pin("economy", regulator_economy, 1'b1);
            cmp_pin("irq", irq, 1'b1);
            rd(IST, 32'h1, 32'h1);
            cyc(3);
            cmp_pin("irq", irq, 1'b0);
        end
        fast <= 3'h1;
        cyc(8);
        cmp_pin("irq", irq, 1'b0);
        wr(IMK, 32'h2);
        cyc(3);
        cmp_pin("irq", irq, 1'b1);
        rd(IST, 32'h3, 32'h2);
        crystal_sleep_stop_ctl <= 1'b1;
        cpu_sleep <= 1'b1;
        fast <= 3'h0;
        cyc(6);
        cmp_pin("economy", regulator_economy, 1'b1);
        cyc(ECO + 10);
        rd(IST, 32'h1, 32'h0);
        cpu_sleep <= 1'b0;
        cyc(6);
        cmp_pin("economy", regulator_economy, 1'b1);
        fast <= 3'h4;
        cyc(6);
        cmp_pin("economy", regulator_economy, 1'b0);
        crystal_sleep_stop_ctl <= 1'b0;
        cpu_sleep <= 1'b1;
        fast <= 3'h0;
        cyc(ECO / 2);
        cmp_pin("economy", regulator_economy, 1'b0);
        cyc(ECO);
        cmp_pin("economy", regulator_economy, 1'b1);
        rd(IST, 32'h1, 32'h1);
        cpu_sleep <= 1'b0;
        fast <= 3'h2;
        cyc(6);
        cmp_pin("economy", regulator_economy, 1'b0);
        wr(TIM, 32'h1);
        rd(TIM, 32'h3, 32'h1);
        cmp_pin("divider", charge_pump_clk_div === 2'h1, 1'b1);
        fast <= 3'h0;
        cyc(ECO + 10);
        rd(IST, 32'h1, 32'h1);
        rd(STA, 32'h40, 32'h40);
        wr(STA, 32'h1);
        rd(STA, 32'h40, 32'h0);
        wr(MOD, 32'h5);
        cyc(6);
        cmp_pin("pump", charge_pump_en, 1'b1);
        rd(STA, 32'h1f, 32'h8);
        cpu_sleep <= 1'b1;
        cyc(6);
        cmp_pin("pump", charge_pump_en, 1'b1);
        cpu_sleep <= 1'b0;
        wr(MOD, 32'h0);
        wr(PRT, key);
        rd(IST, 32'h1, 32'h0);
        cmp_pin("pump", charge_pump_en, 1'b0);
        rd(STA, 32'h10, 32'h10);
        cyc(SUP);
        rd(IST, 32'h1, 32'h1);
        rd(STA, 32'h40, 32'h40);
        final_report();
    end
endmodule
